// ### rtl/gpt_defs.svh
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
`define GPT_A_CFG 8'h00
`define GPT_A_MODEA 8'h04
`define GPT_A_MODEB 8'h08
`define GPT_A_CTL 8'h0c
`define GPT_A_IMR 8'h18
`define GPT_A_RIS 8'h1c
`define GPT_A_MIS 8'h20
`define GPT_A_ICR 8'h24
`define GPT_A_ILRA 8'h28
`define GPT_A_ILRB 8'h2c
`define GPT_A_MATCH 8'h30
`define GPT_A_PRA 8'h38
`define GPT_A_PRB 8'h3c
`define GPT_A_CNTA 8'h48
`define GPT_A_CNTB 8'h4c
`define GPT_C_EN_A 0
`define GPT_C_STALL_A 1
`define GPT_C_RTC_RUN_ENABLE 4
`define GPT_C_TOTE_A 5
`define GPT_C_EN_B 8
`define GPT_C_STALL_B 9
`define GPT_I_TO_A 0
`define GPT_I_RTC 3
`define GPT_I_TO_B 8
`define GPT_IRQ_W 9
`define GPT_HALF_RST 16'hffff
`define GPT_PR_RST 8'h00
`define GPT_RTC_DIV 32768
`endif

// ### rtl/gpt_pkg.sv
`default_nettype none
package gpt_pkg;
	// Configuration codes of the timer pair.
	typedef enum logic [2:0]
	{
		GPT_CFG_32 = 3'h0,
		GPT_CFG_RTC = 3'h1,
		GPT_CFG_16 = 3'h4
	} gpt_cfg_e;
	// Half mode field codes.
	typedef enum logic [1:0]
	{
		GPT_MODE_OFF = 2'h0,
		GPT_MODE_ONESHOT = 2'h1,
		GPT_MODE_PERIODIC = 2'h2,
		GPT_MODE_RSVD = 2'h3
	} gpt_mode_e;
	// One Wishbone request from the master.
	typedef struct packed
	{
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} gpt_wb_s;
endpackage
`default_nettype wire

// ### rtl/gpt_timer.sv
`include "gpt_defs.svh"
`default_nettype none
module gpt_timer #(
	parameter int RTC_DIV = `GPT_RTC_DIV,
	parameter bit HAS_PINS = 1'b1
) (
	input wire logic clock,
	input wire logic rst,
	input wire gpt_pkg::gpt_wb_s wb_req,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic capture_pin_even,
	output logic trig_o,
	output logic irq_o
);
	localparam int DW = $clog2(RTC_DIV);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	gpt_pkg::gpt_cfg_e cfg_q;
	gpt_pkg::gpt_mode_e mode_q [2];
	logic [1:0] en_q;
	logic [1:0] stall_q;
	logic rtc_run_enable_q;
	logic tote_q;
	logic [`GPT_IRQ_W-1:0] imr_q;
	logic [`GPT_IRQ_W-1:0] ris_q;
	logic [`GPT_IRQ_W-1:0] ris_d;
	logic [1:0][15:0] ilr_q;
	logic [1:0][15:0] cnt_q;
	logic [31:0] cnt_d;
	logic [31:0] match_q;
	logic [7:0] pr_q [2];
	logic ack_q;
	logic [31:0] rdat_q;
	logic trig_q;
	logic irq_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic acc;
	logic wr;
	logic is16;
	logic [31:0] rd_mux;
	logic [31:0] wv;
	logic [1:0] ilr_wr;
	logic rtc_load;
	logic ctl_wr;
	logic [`GPT_IRQ_W-1:0] clr;

	// Merges written byte lanes over the current register value.
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// A request is taken at the edge on which the ack is already high.
	assign acc = wb_req.cyc & wb_req.stb & ack_q;
	assign wr = acc & wb_req.we;
	assign is16 = (cfg_q == gpt_pkg::GPT_CFG_16);
	assign wv = lane_merge(rd_mux, wb_req.dat, wb_req.sel);
	assign ctl_wr = wr && (wb_req.adr == `GPT_A_CTL);

	// Read multiplexer; unmapped words read as zero.
	always_comb
	begin
		rd_mux = 32'h0;
		case (wb_req.adr)
			`GPT_A_CFG: rd_mux = {29'h0, cfg_q};
			`GPT_A_MODEA: rd_mux = {30'h0, mode_q[0]};
			`GPT_A_MODEB: rd_mux = {30'h0, mode_q[1]};
			`GPT_A_CTL:
			begin
				rd_mux[`GPT_C_EN_A] = en_q[0];
				rd_mux[`GPT_C_STALL_A] = stall_q[0];
				rd_mux[`GPT_C_RTC_RUN_ENABLE] = rtc_run_enable_q;
				rd_mux[`GPT_C_TOTE_A] = tote_q;
				rd_mux[`GPT_C_EN_B] = en_q[1];
				rd_mux[`GPT_C_STALL_B] = stall_q[1];
			end
			`GPT_A_IMR: rd_mux = {23'h0, imr_q};
			`GPT_A_RIS: rd_mux = {23'h0, ris_q};
			`GPT_A_MIS: rd_mux = {23'h0, ris_q & imr_q};
			`GPT_A_ILRA: rd_mux = is16 ? {16'h0, ilr_q[0]} : ilr_q;
			`GPT_A_ILRB: rd_mux = {16'h0, ilr_q[1]};
			`GPT_A_MATCH: rd_mux = match_q;
			`GPT_A_PRA: rd_mux = {24'h0, pr_q[0]};
			`GPT_A_PRB: rd_mux = {24'h0, pr_q[1]};
			`GPT_A_CNTA: rd_mux = is16 ? {16'h0, cnt_q[0]} : cnt_q;
			`GPT_A_CNTB: rd_mux = {16'h0, cnt_q[1]};
			default: rd_mux = 32'h0;
		endcase
	end

	// Side effects of writes.
	always_comb
	begin
		ilr_wr = 2'b00;
		clr = '0;
		rtc_load = 1'b0;
		if (wr)
		begin
			case (wb_req.adr)
				`GPT_A_ILRA: ilr_wr = is16 ? 2'b01 : 2'b11;
				`GPT_A_ILRB: ilr_wr = is16 ? 2'b10 : 2'b00;
				`GPT_A_ICR: clr = wv[`GPT_IRQ_W-1:0];
				`GPT_A_CFG: rtc_load = (wv[2:0] == gpt_pkg::GPT_CFG_RTC)
					&& (cfg_q != gpt_pkg::GPT_CFG_RTC);
				default: ilr_wr = 2'b00;
			endcase
		end
	end

	// One-wait-state Wishbone answer with registered read data.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
			rdat_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// Configuration and control registers
	// ----------------------------------------
	logic [1:0] stop;

	// Software writes; a one-shot end clears the enable unless CTL is written.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cfg_q <= gpt_pkg::GPT_CFG_32;
			mode_q[0] <= gpt_pkg::GPT_MODE_OFF;
			mode_q[1] <= gpt_pkg::GPT_MODE_OFF;
			en_q <= 2'b00;
			stall_q <= 2'b00;
			rtc_run_enable_q <= 1'b0;
			tote_q <= 1'b0;
			imr_q <= '0;
			match_q <= 32'h0;
			pr_q[0] <= `GPT_PR_RST;
			pr_q[1] <= `GPT_PR_RST;
		end
		else
		begin
			if (wr && wb_req.adr == `GPT_A_CFG)
				cfg_q <= gpt_pkg::gpt_cfg_e'(wv[2:0]);
			if (wr && wb_req.adr == `GPT_A_MODEA)
				mode_q[0] <= gpt_pkg::gpt_mode_e'(wv[1:0]);
			if (wr && wb_req.adr == `GPT_A_MODEB)
				mode_q[1] <= gpt_pkg::gpt_mode_e'(wv[1:0]);
			if (wr && wb_req.adr == `GPT_A_IMR)
				imr_q <= wv[`GPT_IRQ_W-1:0];
			if (wr && wb_req.adr == `GPT_A_MATCH)
				match_q <= wv;
			if (wr && wb_req.adr == `GPT_A_PRA)
				pr_q[0] <= wv[7:0];
			if (wr && wb_req.adr == `GPT_A_PRB)
				pr_q[1] <= wv[7:0];
			if (ctl_wr)
			begin
				en_q <= {wv[`GPT_C_EN_B], wv[`GPT_C_EN_A]};
				stall_q <= {wv[`GPT_C_STALL_B], wv[`GPT_C_STALL_A]};
				rtc_run_enable_q <= wv[`GPT_C_RTC_RUN_ENABLE];
				tote_q <= wv[`GPT_C_TOTE_A];
			end
			else
				en_q <= en_q & ~stop;
		end
	end

	// Load registers take the write; 32-bit modes fill both halves.
	always_ff @(posedge clock)
	begin
		if (rst)
			ilr_q <= {`GPT_HALF_RST, `GPT_HALF_RST};
		else
		begin
			if (ilr_wr[0])
				ilr_q[0] <= wv[15:0];
			if (ilr_wr[1])
				ilr_q[1] <= is16 ? wv[15:0] : wv[31:16];
		end
	end

	// ----------------------------------------
	// Capture pin and one-second divider
	// ----------------------------------------
	logic pin_in;
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic [DW-1:0] div_q;
	logic tick;

	// Instances without pins see a quiet input.
	assign pin_in = HAS_PINS ? capture_pin_even : 1'b0;

	// Two-stage synchroniser, then a delayed copy for edge detection.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Counts rising edges of the slow clock; wraps once per second.
	assign tick = pin_s2_q & ~pin_s3_q & (div_q == DW'(RTC_DIV - 1));
	always_ff @(posedge clock)
	begin
		if (rst || cfg_q != gpt_pkg::GPT_CFG_RTC || !en_q[0])
			div_q <= '0;
		else if (pin_s2_q & ~pin_s3_q)
			div_q <= tick ? '0 : DW'(div_q + 1'b1);
	end

	// ----------------------------------------
	// Counter core
	// ----------------------------------------
	logic [31:0] cnt32;
	logic run32;
	logic rtc_run;
	logic rtc_hit;
	logic [1:0] to;

	assign cnt32 = cnt_q;
	assign run32 = en_q[0] & ~stall_q[0];
	assign rtc_run = en_q[0] & (rtc_run_enable_q | ~(|stall_q));

	// Next count for each configuration; load writes take priority in the 32-bit and 16-bit ones.
	always_comb
	begin
		cnt_d = cnt32;
		to = 2'b00;
		stop = 2'b00;
		rtc_hit = 1'b0;
		case (cfg_q)
			gpt_pkg::GPT_CFG_32:
			begin
				if (ilr_wr[0])
					cnt_d = wv;
				else if (run32)
				begin
					if (cnt32 == 32'h0)
					begin
						cnt_d = ilr_q;
						stop[0] = (mode_q[0] == gpt_pkg::GPT_MODE_ONESHOT);
					end
					else
					begin
						cnt_d = cnt32 - 32'h1;
						to[0] = (cnt32 == 32'h1);
					end
				end
			end
			gpt_pkg::GPT_CFG_RTC:
			begin
				if (tick && rtc_run)
				begin
					rtc_hit = (cnt32 == match_q);
					cnt_d = rtc_hit ? 32'h0 : cnt32 + 32'h1;
				end
			end
			gpt_pkg::GPT_CFG_16:
			begin
				for (int h = 0; h < 2; h++)
				begin
					if (ilr_wr[h])
						cnt_d[h*16 +: 16] = wv[15:0];
					else if (en_q[h] && !stall_q[h])
					begin
						if (cnt_q[h] == 16'h0)
						begin
							cnt_d[h*16 +: 16] = ilr_q[h];
							stop[h] = (mode_q[h] == gpt_pkg::GPT_MODE_ONESHOT);
						end
						else
						begin
							cnt_d[h*16 +: 16] = cnt_q[h] - 16'h1;
							to[h] = (cnt_q[h] == 16'h1);
						end
					end
				end
			end
			default: cnt_d = cnt32;
		endcase
		if (rtc_load)
			cnt_d = 32'h1;
	end

	// Count register.
	always_ff @(posedge clock)
	begin
		if (rst)
			cnt_q <= {`GPT_HALF_RST, `GPT_HALF_RST};
		else
			cnt_q <= cnt_d;
	end

	// ----------------------------------------
	// Status, interrupt and trigger
	// ----------------------------------------
	always_comb
	begin
		ris_d = ris_q & ~clr;
		ris_d[`GPT_I_TO_A] = ris_d[`GPT_I_TO_A] | to[0];
		ris_d[`GPT_I_TO_B] = ris_d[`GPT_I_TO_B] | to[1];
		ris_d[`GPT_I_RTC] = ris_d[`GPT_I_RTC] | rtc_hit;
	end

	// Set wins over a clear in the same cycle; the trigger is a single pulse.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ris_q <= '0;
			trig_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ris_q <= ris_d;
			trig_q <= tote_q & to[0];
			irq_q <= |(ris_d & imr_q);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign trig_o = trig_q;
	assign irq_o = irq_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_trig_one_cycle: assert property (trig_q |=> !trig_q)
		else $error("trigger longer than one cycle");
	a_trig_with_raw: assert property (trig_q |-> ris_q[`GPT_I_TO_A])
		else $error("trigger without raw time-out");
	a_count_down: assert property ((cfg_q == gpt_pkg::GPT_CFG_32) && run32 && !rtc_load
		&& cnt32 != 32'h0 && ilr_wr == 2'b00 |=> cnt32 == $past(cnt32) - 32'h1)
		else $error("32-bit count did not decrement");
	a_zero_reload: assert property ((cfg_q == gpt_pkg::GPT_CFG_32) && run32 && !rtc_load
		&& cnt32 == 32'h0 && ilr_wr == 2'b00 |=> cnt32 == $past(ilr_q))
		else $error("no reload after zero");
	a_oneshot_stop: assert property ((cfg_q == gpt_pkg::GPT_CFG_32) && run32
		&& cnt32 == 32'h0 && mode_q[0] == gpt_pkg::GPT_MODE_ONESHOT && !ctl_wr
		|=> !en_q[0])
		else $error("one-shot enable not cleared");
	a_stall_hold: assert property ((cfg_q == gpt_pkg::GPT_CFG_32) && stall_q[0] && !rtc_load
		&& ilr_wr == 2'b00 |=> cnt32 == $past(cnt32))
		else $error("stalled counter moved");
	a_raw_sticky: assert property (ris_q[`GPT_I_TO_A]
		&& !clr[`GPT_I_TO_A] |=> ris_q[`GPT_I_TO_A])
		else $error("raw time-out lost");
	a_load_write: assert property (!is16 && cfg_q == gpt_pkg::GPT_CFG_32
		&& ilr_wr[0] |=> cnt32 == $past(wv) && ilr_q == $past(wv))
		else $error("load write not taken");
	a_rtc_first: assert property (rtc_load |=> cnt32 == 32'h1)
		else $error("clock mode not loaded with one");
	a_rtc_roll: assert property (rtc_hit |=> cnt32 == 32'h0
		&& ris_q[`GPT_I_RTC])
		else $error("no rollover on match");
	a_rtc_nostall: assert property ((cfg_q == gpt_pkg::GPT_CFG_RTC) && tick
		&& en_q[0] && rtc_run_enable_q && !rtc_load && cnt32 != match_q
		|=> cnt32 == $past(cnt32) + 32'h1)
		else $error("clock count frozen by stall");
	a_ack_pulse: assert property (ack_q |=> !ack_q)
		else $error("ack held two cycles");
endmodule
`default_nettype wire

// ### tb/gp_timer_32bit_modes_tb_top.sv
`default_nettype none
module gp_timer_32bit_modes_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock;
	logic rst;
	logic slow_pin;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic trig_o;
	logic irq_o;
	gpt_pkg::gpt_wb_s wb_req;
	int fail_count;
	int total_checks;
	int cycles;
	// ----------------------------------------
	// Design, slow clock source and clock
	// ----------------------------------------
	gpt_timer #(.RTC_DIV(4), .HAS_PINS(1'b1)) u_dut (
		.clock(clock),
		.rst(rst),
		.wb_req(wb_req),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.capture_pin_even(slow_pin),
		.trig_o(trig_o),
		.irq_o(irq_o)
	);
	gpt_slow_src u_src (
		.pin(slow_pin)
	);
	initial
	begin
		clock = 1'b0;
		forever
		begin
			#12.5 clock = ~clock;
		end
	end
	// Cuts a hung run short after a generous cycle budget.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			complete_run();
		end
	end
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One classic cycle: hold the request until ack is sampled high, then release.
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clock);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
		do
			@(posedge clock);
		while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_req <= '0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		logic [31:0] unused;
		xfer(1'b1, adr, wd, unused);
	endtask
	task automatic rd(input logic [7:0] adr, output logic [31:0] rdat);
		xfer(1'b0, adr, 32'h0, rdat);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values of seven registers of the map, plus one unmapped address that must read zero.
	task automatic t_reset();
		logic [7:0] a[8] = '{8'h00, 8'h0c, 8'h28, 8'h2c, 8'h48, 8'h38, 8'h3c, 8'h80};
		logic [31:0] e[8] = '{32'h0, 32'h0, 32'hffffffff, 32'h0000ffff, 32'hffffffff,
			32'h0, 32'h0, 32'h0};
		logic [31:0] d;
		for (int i = 0; i < 8; i++)
		begin
			rd(a[i], d);
			chk("reset value", e[i], d);
		end
	endtask
	// A 32-bit load splits over both halves and the count reads back joined.
	task automatic t_split();
		logic [31:0] d;
		wr(8'h28, 32'hbeef0007);
		rd(8'h2c, d);
		chk("half b load", 32'h0000beef, d);
		rd(8'h48, d);
		chk("joined count", 32'hbeef0007, d);
	endtask
	// One-shot run with trigger and unmasked time-out; half B mode set to periodic.
	task automatic t_oneshot();
		logic [31:0] d;
		int n;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h2);
		wr(8'h18, 32'h1);
		wr(8'h28, 32'h5);
		wr(8'h0c, 32'h21);
		n = 0;
		do
		begin
			@(posedge clock);
			#1;
			n++;
		end
		while (trig_o !== 1'b1 && n < 20);
		chk("cycles to zero", 32'd5, n);
		chk("irq at zero", 32'h1, {31'h0, irq_o});
		@(posedge clock);
		#1;
		chk("trigger width", 32'h0, {31'h0, trig_o});
		rd(8'h0c, d);
		chk("enable cleared", 32'h20, d);
		rd(8'h48, d);
		chk("reloaded count", 32'h5, d);
		rd(8'h20, d);
		chk("masked status", 32'h1, d);
		wr(8'h24, 32'h1);
		rd(8'h1c, d);
		chk("raw cleared", 32'h0, d);
	endtask
	// Stall hold, periodic pulses with the time-out masked, and a load while running.
	task automatic t_periodic();
		logic [31:0] d;
		logic [31:0] d2;
		int p;
		wr(8'h04, 32'h2);
		wr(8'h18, 32'h0);
		wr(8'h28, 32'h3);
		wr(8'h0c, 32'h23);
		rd(8'h48, d);
		repeat (5) @(posedge clock);
		rd(8'h48, d2);
		chk("stalled count", 32'h3, d2);
		wr(8'h0c, 32'h21);
		p = 0;
		repeat (16)
		begin
			@(posedge clock);
			#1;
			p += int'(trig_o === 1'b1);
		end
		chk("periodic pulses", 32'd4, p);
		chk("masked irq", 32'h0, {31'h0, irq_o});
		rd(8'h1c, d);
		chk("raw held", 32'h1, d);
		wr(8'h28, 32'h1000);
		rd(8'h48, d);
		chk("new load taken", 32'h1, {31'h0, d <= 32'h1000 && d > 32'hff0});
		wr(8'h0c, 32'h0);
		wr(8'h24, 32'h1);
	endtask
	// Clock mode: start at one, count on the divided tick through stall, match to zero.
	task automatic t_rtc();
		logic [31:0] d;
		int n;
		wr(8'h30, 32'h2);
		wr(8'h18, 32'h8);
		wr(8'h00, 32'h1);
		rd(8'h48, d);
		chk("clock start", 32'h1, d);
		wr(8'h0c, 32'h13);
		n = 0;
		do
		begin
			@(posedge clock);
			#1;
			n++;
		end
		while (irq_o !== 1'b1 && n < 12000);
		chk("two ticks", 32'h1, {31'h0, n > 8400 && n < 9900});
		rd(8'h48, d);
		chk("rolled over", 32'h0, d);
		rd(8'h20, d);
		chk("match masked", 32'h8, d);
		wr(8'h24, 32'h8);
		rd(8'h1c, d);
		chk("match cleared", 32'h0, d);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wr(8'h0c, 32'h0);
	endtask
	// Sixteen-bit configuration keeps the halves apart on load and count.
	task automatic t_half();
		logic [31:0] d;
		wr(8'h00, 32'h4);
		wr(8'h28, 32'h00120034);
		rd(8'h28, d);
		chk("half a load alone", 32'h00000034, d);
		rd(8'h2c, d);
		chk("half b load kept", 32'h0, d);
		rd(8'h48, d);
		chk("half a count alone", 32'h00000034, d);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		wb_req = '0;
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_split();
		t_oneshot();
		t_periodic();
		t_rtc();
		t_half();
		complete_run();
	end
endmodule
`default_nettype wire

// ### tb/gpt_slow_src.sv
`default_nettype none
// ----------------------------------------
// Slow reference clock source
// ----------------------------------------
module gpt_slow_src #(
	parameter real HALF_NS = 15258.789
) (
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Free running 32.768 kHz square wave, phase unrelated to the system clock.
	initial
	begin
		pin = 1'b0;
		#7.3;
		forever
		begin
			#(HALF_NS) pin = ~pin;
		end
	end
endmodule
`default_nettype wire
